//--- include/tcc_defines.svh
// Timer counter register map, field positions, reset values and timing constants
`ifndef TCC_DEFINES_SVH
`define TCC_DEFINES_SVH
`define TCC_OFS_MODE    6'h00
`define TCC_OFS_CTL     6'h04
`define TCC_OFS_CLKSEL  6'h08
`define TCC_OFS_CMODE1  6'h0C
`define TCC_OFS_CMODE2  6'h10
`define TCC_OFS_CMP1    6'h14
`define TCC_OFS_CMP2    6'h18
`define TCC_OFS_CAPT    6'h1C
`define TCC_OFS_STATUS  6'h20
`define TCC_OFS_CLEAR   6'h24
`define TCC_OFS_INTEN   6'h28
`define TCC_CTL_RUN     0
`define TCC_CTL_PRESET  1
`define TCC_CTL_EIM     2
`define TCC_CM_IRQ      0
`define TCC_CM_RST      1
`define TCC_CM_TGL      2
`define TCC_CM_SGL      3
`define TCC_CS_SRC_LSB  0
`define TCC_CS_EDGE_LSB 2
`define TCC_ST_RUN      0
`define TCC_ST_CM1      1
`define TCC_ST_CM2      2
`define TCC_ST_EDGE     3
`define TCC_RST_MODE    4'hF
`define TCC_RST_CMP     8'hFF
`define TCC_RST_ZERO4   4'h0
`define TCC_PRE_DIV     16
`endif

//--- include/tcc_pkg.sv
// Timer counter types: modes, states, count sources and edge selections
package tcc_pkg;
  typedef enum logic [3:0] {
    TCC_M_TIMER    = 4'h1,
    TCC_M_TRIG_EXT = 4'h2,
    TCC_M_TRIG_T2  = 4'h3,
    TCC_M_TIMER_PT = 4'h4,
    TCC_M_TRIG_PT  = 4'h5,
    TCC_M_BURST_M2 = 4'h6,
    TCC_M_BURST_SO = 4'h7,
    TCC_M_FSK      = 4'h8,
    TCC_M_PWM      = 4'h9,
    TCC_M_MANCH    = 4'hA,
    TCC_M_BIPH     = 4'hB,
    TCC_M_CAPT     = 4'hC
  } tcc_mode_type;
  typedef enum logic [1:0] {
    TCC_IDLE  = 2'b00,
    TCC_ARMED = 2'b01,
    TCC_COUNT = 2'b11,
    TCC_HOLD  = 2'b10
  } tcc_state_type;
  typedef enum logic [1:0] {
    TCC_SRC_SYS = 2'h0,
    TCC_SRC_PRE = 2'h1,
    TCC_SRC_EXT = 2'h2,
    TCC_SRC_T2  = 2'h3
  } tcc_src_type;
  typedef enum logic [1:0] {
    TCC_EDGE_OFF  = 2'h0,
    TCC_EDGE_RISE = 2'h1,
    TCC_EDGE_FALL = 2'h2,
    TCC_EDGE_BOTH = 2'h3
  } tcc_edge_type;
endpackage

//--- logic/tcc_timer3.sv
// Eight-bit compare/capture timer with modulator and demodulator stage
//
// The Avalon-MM slave port and the address map were decided locally.
`timescale 1ns/1ps
`include "tcc_defines.svh"
module tcc_timer3
  import tcc_pkg::*;
#(
  parameter int WIDTH   = 8,
  parameter int PRE_DIV = `TCC_PRE_DIV
) (
  // Clock and reset
  input  wire logic             CLK,
  input  wire logic             SYS_RST,
  // Avalon-MM slave
  input  wire logic [5:0]       AVS_ADDRESS,
  input  wire logic             AVS_READ,
  input  wire logic             AVS_WRITE,
  input  wire logic [31:0]      AVS_WRITEDATA,
  input  wire logic [3:0]       AVS_BYTEENABLE,
  output logic      [31:0]      AVS_READDATA,
  output logic                  AVS_WAITREQUEST,
  // Timer pins and neighbours
  input  wire logic             TIMER_EDGE_INPUT,
  input  wire logic             T2_TOGGLE_IN,
  input  wire logic             T2_OUTPUT_IN,
  input  wire logic             T2_GATE_IN,
  input  wire logic             SERIAL_SHIFT_DATA_IN,
  output logic                  TIMER_SIGNAL_OUTPUT,
  output logic                  TIMER_TOGGLE_OUT,
  output logic                  SERIAL_SHIFT_BIT,
  output logic                  SERIAL_SHIFT_STROBE,
  // Interrupt
  output logic                  IRQ
);

  function automatic logic hit(input logic [5:0] ofs);
    hit = (AVS_ADDRESS == ofs);
  endfunction

  function automatic logic is_trig(input logic [3:0] m);
    is_trig = (m == TCC_M_TRIG_EXT) || (m == TCC_M_TRIG_PT);
  endfunction

  function automatic logic is_demod(input logic [3:0] m);
    is_demod = (m == TCC_M_MANCH) || (m == TCC_M_BIPH);
  endfunction

  function automatic logic is_capt(input logic [3:0] m);
    is_capt = is_trig(m) || (m == TCC_M_TRIG_T2) || (m == TCC_M_CAPT);
  endfunction

  logic [3:0]       mode_timer_mode_select_reg_r;
  logic [2:0]       timer_control_reg_r;
  logic [3:0]       clksel_r;
  logic [3:0]       compare_action_mask_one_r;
  logic [3:0]       compare_action_mask_two_r;
  logic [WIDTH-1:0] compare_value_one_r;
  logic [WIDTH-1:0] compare_value_two_r;
  logic [WIDTH-1:0] cnt_r;
  logic [WIDTH-1:0] capt_r;
  logic [3:0]       sticky_r;
  logic [3:0]       inten_r;
  logic [3:0]       sticky_set;
  logic [3:0]       sticky_clr;
  tcc_state_type    state_r;
  tcc_state_type    state_nxt;
  logic             ack_r;
  logic             req;
  logic             wr_en;
  logic [7:0]       wdat;
  logic [31:0]      rd_nxt;
  logic             sy1_r;
  logic             sy2_r;
  logic             sy3_r;
  logic             t2_prev_r;
  logic [15:0]      pre_cnt_r;
  logic             pre_tick;
  logic             rise;
  logic             fall;
  logic             edge_act;
  logic             t2_evt;
  logic             tick;
  logic             run;
  logic             counting;
  logic             act_sel;
  logic             sel_r;
  logic             done1_r;
  logic             done2_r;
  logic             m1;
  logic             m2;
  logic             restart;
  logic             capt_evt;
  logic             tgl_r;
  logic             bip_r;
  logic [3:0]       mode;

  assign mode = mode_timer_mode_select_reg_r;
  assign run  = timer_control_reg_r[`TCC_CTL_RUN];

  // Bus: one wait state, write lands on the edge where waitrequest is low
  assign req             = AVS_READ | AVS_WRITE;
  assign AVS_WAITREQUEST = req & ~ack_r;
  assign wr_en           = AVS_WRITE & ack_r & AVS_BYTEENABLE[0];
  assign wdat            = AVS_WRITEDATA[7:0];

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req & ~ack_r;
    end
  end

  always_comb begin
    rd_nxt = 32'h0000_0000;
    if (hit(`TCC_OFS_MODE)) begin
      rd_nxt[3:0] = mode;
    end else if (hit(`TCC_OFS_CTL)) begin
      rd_nxt[2:0] = timer_control_reg_r;
    end else if (hit(`TCC_OFS_CLKSEL)) begin
      rd_nxt[3:0] = clksel_r;
    end else if (hit(`TCC_OFS_CMODE1)) begin
      rd_nxt[3:0] = compare_action_mask_one_r;
    end else if (hit(`TCC_OFS_CMODE2)) begin
      rd_nxt[3:0] = compare_action_mask_two_r;
    end else if (hit(`TCC_OFS_CMP1)) begin
      rd_nxt[WIDTH-1:0] = compare_value_one_r;
    end else if (hit(`TCC_OFS_CMP2)) begin
      rd_nxt[WIDTH-1:0] = compare_value_two_r;
    end else if (hit(`TCC_OFS_CAPT)) begin
      rd_nxt[WIDTH-1:0] = capt_r;
    end else if (hit(`TCC_OFS_STATUS)) begin
      rd_nxt[3:0] = {sticky_r[3:1], counting};
    end else if (hit(`TCC_OFS_INTEN)) begin
      rd_nxt[3:0] = inten_r;
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      AVS_READDATA <= 32'h0000_0000;
    end else if (AVS_READ & ~ack_r) begin
      AVS_READDATA <= rd_nxt;
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      mode_timer_mode_select_reg_r <= `TCC_RST_MODE;
      timer_control_reg_r          <= 3'h0;
      clksel_r                     <= `TCC_RST_ZERO4;
      compare_action_mask_one_r    <= `TCC_RST_ZERO4;
      compare_action_mask_two_r    <= `TCC_RST_ZERO4;
      compare_value_one_r          <= WIDTH'(`TCC_RST_CMP);
      compare_value_two_r          <= WIDTH'(`TCC_RST_CMP);
      inten_r                      <= `TCC_RST_ZERO4;
    end else if (wr_en) begin
      if (hit(`TCC_OFS_MODE)) begin
        mode_timer_mode_select_reg_r <= wdat[3:0];
      end else if (hit(`TCC_OFS_CTL)) begin
        timer_control_reg_r <= wdat[2:0];
      end else if (hit(`TCC_OFS_CLKSEL)) begin
        clksel_r <= wdat[3:0];
      end else if (hit(`TCC_OFS_CMODE1)) begin
        compare_action_mask_one_r <= wdat[3:0];
      end else if (hit(`TCC_OFS_CMODE2)) begin
        compare_action_mask_two_r <= wdat[3:0];
      end else if (hit(`TCC_OFS_CMP1)) begin
        compare_value_one_r <= wdat[WIDTH-1:0];
      end else if (hit(`TCC_OFS_CMP2)) begin
        compare_value_two_r <= wdat[WIDTH-1:0];
      end else if (hit(`TCC_OFS_INTEN)) begin
        inten_r <= {wdat[3:1], 1'b0};
      end
    end
  end

  // Input stage; first flop feeds only the second
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      sy1_r     <= 1'b0;
      sy2_r     <= 1'b0;
      sy3_r     <= 1'b0;
      t2_prev_r <= 1'b0;
    end else begin
      sy1_r     <= TIMER_EDGE_INPUT;
      sy2_r     <= sy1_r;
      sy3_r     <= sy2_r;
      t2_prev_r <= T2_TOGGLE_IN;
    end
  end

  assign rise   = sy2_r & ~sy3_r;
  assign fall   = ~sy2_r & sy3_r;
  assign t2_evt = T2_TOGGLE_IN ^ t2_prev_r;

  always_comb begin
    case (tcc_edge_type'(clksel_r[`TCC_CS_EDGE_LSB +: 2]))
      TCC_EDGE_RISE: edge_act = rise;
      TCC_EDGE_FALL: edge_act = fall;
      TCC_EDGE_BOTH: edge_act = rise | fall;
      default:       edge_act = 1'b0;
    endcase
  end

  // Prescaler runs freely so the internal slow source needs no restart
  always_ff @(posedge CLK) begin
    if (SYS_RST || pre_tick) begin
      pre_cnt_r <= 16'h0000;
    end else begin
      pre_cnt_r <= pre_cnt_r + 16'h0001;
    end
  end

  assign pre_tick = (pre_cnt_r == 16'(PRE_DIV - 1));

  always_comb begin
    case (tcc_src_type'(clksel_r[`TCC_CS_SRC_LSB +: 2]))
      TCC_SRC_PRE: tick = pre_tick;
      TCC_SRC_EXT: tick = edge_act;
      TCC_SRC_T2:  tick = t2_evt;
      default:     tick = 1'b1;
    endcase
  end

  // Sequencer
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      TCC_IDLE: begin
        if (run) begin
          state_nxt = (is_trig(mode) || is_demod(mode)) ? TCC_ARMED : TCC_COUNT;
        end
      end
      TCC_ARMED: begin
        if (!run) begin
          state_nxt = TCC_IDLE;
        end else if (edge_act) begin
          state_nxt = TCC_COUNT;
        end
      end
      TCC_COUNT: begin
        if (!run) begin
          state_nxt = TCC_IDLE;
        end else if (is_demod(mode) && m1) begin
          state_nxt = TCC_HOLD;
        end
      end
      default: begin
        if (!run) begin
          state_nxt = TCC_IDLE;
        end else if (edge_act) begin
          state_nxt = TCC_COUNT;
        end
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      state_r <= TCC_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign counting = (state_r == TCC_COUNT) || (state_r == TCC_HOLD);

  // FSK and PWM let the shift data pick the compare register
  assign act_sel = ((mode == TCC_M_FSK) || (mode == TCC_M_PWM)) ?
                   SERIAL_SHIFT_DATA_IN : sel_r;

  // Match on count x gives a period of x + 1 ticks
  assign m1 = counting && tick && (cnt_r == compare_value_one_r) && !act_sel &&
              !done1_r && (state_r != TCC_HOLD);
  assign m2 = counting && tick && (cnt_r == compare_value_two_r) && act_sel &&
              !done2_r;

  assign restart = (state_r == TCC_HOLD && edge_act) ||
                   (is_trig(mode) && state_r == TCC_COUNT && edge_act) ||
                   (mode == TCC_M_TRIG_T2 && counting && t2_evt);
  assign capt_evt = (restart && !is_demod(mode)) ||
                    (mode == TCC_M_CAPT && counting && edge_act);

  always_ff @(posedge CLK) begin
    if (SYS_RST || !run) begin
      cnt_r <= '0;
    end else if (restart || state_r == TCC_ARMED) begin
      cnt_r <= '0;
    end else if (counting && tick) begin
      if ((m1 && compare_action_mask_one_r[`TCC_CM_RST]) ||
          (m2 && compare_action_mask_two_r[`TCC_CM_RST])) begin
        cnt_r <= '0;
      end else begin
        cnt_r <= cnt_r + WIDTH'(1);
      end
    end
  end

  // Alternation and single action; a trigger restarts both
  always_ff @(posedge CLK) begin
    if (SYS_RST || state_r == TCC_IDLE || restart) begin
      sel_r   <= 1'b0;
      done1_r <= 1'b0;
      done2_r <= 1'b0;
    end else if (m1) begin
      done1_r <= compare_action_mask_one_r[`TCC_CM_SGL];
      sel_r   <= ~done2_r;
    end else if (m2) begin
      done2_r <= compare_action_mask_two_r[`TCC_CM_SGL];
      sel_r   <= done1_r;
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      tgl_r <= 1'b0;
    end else if (!run) begin
      tgl_r <= timer_control_reg_r[`TCC_CTL_PRESET];
    end else if ((m1 && compare_action_mask_one_r[`TCC_CM_TGL]) ||
                 (m2 && compare_action_mask_two_r[`TCC_CM_TGL])) begin
      tgl_r <= ~tgl_r;
    end
  end

  // Capture copies the live count when no capture mode owns it
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      capt_r <= '0;
    end else if (capt_evt) begin
      capt_r <= cnt_r;
    end else if (!is_capt(mode)) begin
      capt_r <= cnt_r;
    end
  end

  // Demodulator; biphase toggles on each mid-frame edge
  always_ff @(posedge CLK) begin
    if (SYS_RST || state_r == TCC_IDLE) begin
      bip_r <= 1'b0;
    end else if (state_r == TCC_COUNT && edge_act) begin
      bip_r <= ~bip_r;
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      SERIAL_SHIFT_BIT    <= 1'b0;
      SERIAL_SHIFT_STROBE <= 1'b0;
    end else begin
      SERIAL_SHIFT_STROBE <= is_demod(mode) && m1;
      if (is_demod(mode) && m1) begin
        SERIAL_SHIFT_BIT <= (mode == TCC_M_BIPH) ? bip_r : sy2_r;
      end
    end
  end

  // Output stage
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      TIMER_SIGNAL_OUTPUT <= 1'b0;
      TIMER_TOGGLE_OUT    <= 1'b0;
    end else begin
      TIMER_TOGGLE_OUT <= tgl_r;
      case (mode)
        TCC_M_TIMER_PT, TCC_M_TRIG_PT: TIMER_SIGNAL_OUTPUT <= T2_OUTPUT_IN;
        TCC_M_BURST_M2: TIMER_SIGNAL_OUTPUT <= tgl_r & T2_GATE_IN;
        TCC_M_BURST_SO: TIMER_SIGNAL_OUTPUT <= tgl_r & SERIAL_SHIFT_DATA_IN;
        default:        TIMER_SIGNAL_OUTPUT <= tgl_r;
      endcase
    end
  end

  // Interrupt flags; a set in the clearing cycle survives
  always_comb begin
    sticky_set = 4'h0;
    sticky_set[`TCC_ST_CM1]  = m1 && compare_action_mask_one_r[`TCC_CM_IRQ];
    sticky_set[`TCC_ST_CM2]  = m2 && compare_action_mask_two_r[`TCC_CM_IRQ];
    sticky_set[`TCC_ST_EDGE] = edge_act && timer_control_reg_r[`TCC_CTL_EIM] &&
                               !run;
    sticky_clr = (wr_en && hit(`TCC_OFS_CLEAR)) ? wdat[3:0] : 4'h0;
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      sticky_r <= `TCC_RST_ZERO4;
    end else begin
      sticky_r <= (sticky_r & ~sticky_clr) | sticky_set;
    end
  end

  assign IRQ = |(sticky_r[3:1] & inten_r[3:1]);

endmodule

//--- testbench/tcc_timer3_chk.sv
// Port checks: bus wait states, read data, shift strobe and interrupt
`timescale 1ns/1ps
module tcc_timer3_chk (
  // Clock and reset
  input wire logic        CLK,
  input wire logic        SYS_RST,
  // Register bus
  input wire logic        AVS_READ,
  input wire logic        AVS_WRITE,
  input wire logic [31:0] AVS_READDATA,
  input wire logic        AVS_WAITREQUEST,
  // Timer side
  input wire logic        TIMER_SIGNAL_OUTPUT,
  input wire logic        SERIAL_SHIFT_STROBE,
  input wire logic        IRQ
);
  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  chk_first_wait: assert property ($rose(AVS_READ || AVS_WRITE) |-> AVS_WAITREQUEST)
    else $error("no wait state on a new request");
  chk_one_wait: assert property (AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
    else $error("more than one wait state");
  chk_wait_req: assert property (AVS_WAITREQUEST |-> AVS_READ || AVS_WRITE)
    else $error("wait request without a request");
  chk_rd_upper: assert property (AVS_READDATA[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  chk_rd_holds: assert property (!AVS_READ |=> $stable(AVS_READDATA))
    else $error("read data changed without a read");
  chk_strobe_one: assert property (SERIAL_SHIFT_STROBE |=> !SERIAL_SHIFT_STROBE)
    else $error("shift strobe longer than one cycle");
  chk_irq_sticky: assert property ($fell(IRQ) |-> $past(AVS_WRITE && !AVS_WAITREQUEST))
    else $error("interrupt dropped without a register write");
  chk_start_quiet: assert property ($fell(SYS_RST) |-> !IRQ && !TIMER_SIGNAL_OUTPUT)
    else $error("outputs active right after reset");
  cover property ($rose(IRQ));
  cover property (SERIAL_SHIFT_STROBE);
  cover property ($rose(TIMER_SIGNAL_OUTPUT));
endmodule

bind tcc_timer3 tcc_timer3_chk i_tcc_timer3_chk (
  .CLK(CLK), .SYS_RST(SYS_RST), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
  .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
  .TIMER_SIGNAL_OUTPUT(TIMER_SIGNAL_OUTPUT), .SERIAL_SHIFT_STROBE(SERIAL_SHIFT_STROBE),
  .IRQ(IRQ)
);

//--- testbench/tcc_far_model.sv
// Far side: edge source, Timer 2 levels, shift data and decoded-bit sink
`timescale 1ns/1ps
module tcc_far_model (
  // Clock
  input wire logic clk,
  // Lines toward the timer
  output logic     edge_in,
  output logic     t2_tog,
  output logic     t2_out,
  output logic     t2_gate,
  output logic     sdata,
  // Decoded bits from the timer
  input wire logic sbit,
  input wire logic sstb
);
  logic [7:0] shreg = 8'h00;
  int         nbits = 0;
  // Timer 2 lines idle until a scenario moves them; a toggle restarts mode 3
  initial begin
    edge_in = 1'b0;
    t2_tog = 1'b0;
    t2_out = 1'b0;
    t2_gate = 1'b0;
    sdata = 1'b0;
  end
  always @(posedge clk) begin
    if (sstb === 1'b1) begin
      shreg <= {shreg[6:0], sbit};
      nbits <= nbits + 1;
    end
  end
  task automatic set_edge(input logic v);
    @(posedge clk);
    edge_in <= v;
  endtask
  task automatic set_data(input logic v);
    @(posedge clk);
    sdata <= v;
  endtask
  task automatic set_t2(input logic tg, input logic o, input logic g);
    @(posedge clk);
    t2_tog  <= tg;
    t2_out  <= o;
    t2_gate <= g;
  endtask
endmodule

//--- testbench/tb_tcc_timer3.sv
// Self-checking bench for the compare/capture timer
`timescale 1ns/1ps
`include "tcc_defines.svh"
module tb_tcc_timer3;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [5:0]  addr = 6'h00;
  logic        rd_e = 1'b0;
  logic        wr_e = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  be = 4'h0;
  logic [31:0] rdata;
  logic        waitreq, ein, tog, t2o, gate, sdat, sout, togo, sbit, sstb, irq;
  logic [7:0]  q;
  logic [7:0]  ctl_t [3] = '{8'h04, 8'h05, 8'h00};
  logic [7:0]  exp_t [3] = '{8'h01, 8'h00, 8'h00};
  int          bad_count = 0;
  int          n_tests = 0;

  always #5 clk = ~clk;

  tcc_timer3 #(.PRE_DIV(2)) i_tcc_timer3 (
    .CLK(clk), .SYS_RST(rst), .AVS_ADDRESS(addr), .AVS_READ(rd_e), .AVS_WRITE(wr_e),
    .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be), .AVS_READDATA(rdata),
    .AVS_WAITREQUEST(waitreq), .TIMER_EDGE_INPUT(ein), .T2_TOGGLE_IN(tog),
    .T2_OUTPUT_IN(t2o), .T2_GATE_IN(gate), .SERIAL_SHIFT_DATA_IN(sdat),
    .TIMER_SIGNAL_OUTPUT(sout), .TIMER_TOGGLE_OUT(togo), .SERIAL_SHIFT_BIT(sbit),
    .SERIAL_SHIFT_STROBE(sstb), .IRQ(irq)
  );

  tcc_far_model i_tcc_far_model (
    .clk(clk), .edge_in(ein), .t2_tog(tog), .t2_out(t2o), .t2_gate(gate),
    .sdata(sdat), .sbit(sbit), .sstb(sstb)
  );

  task automatic results;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic cmpv(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmpn(input int got, input int exp);
    n_tests++;
    if (got != exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One Avalon transfer; the request stands until waitrequest is sampled low
  task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d,
                     input logic [3:0] b, output logic [7:0] r);
    int n;
    n = 0;
    @(posedge clk);
    addr <= a;
    wdata <= {24'h0, d};
    be <= b;
    wr_e <= w;
    rd_e <= !w;
    do begin
      @(posedge clk);
      n++;
    end while (waitreq !== 1'b0 && n < 50);
    r = rdata[7:0];
    wr_e <= 1'b0;
    rd_e <= 1'b0;
    if (n >= 50)
      cmpn(n, 0);
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    logic [7:0] r;
    bus(1'b1, a, d, 4'hF, r);
  endtask

  task automatic rdc(input logic [5:0] a, input logic [7:0] e);
    logic [7:0] r;
    bus(1'b0, a, 8'h00, 4'hF, r);
    cmpv(r, e);
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Measures one high and one low stretch of the timer output
  task automatic meas(input int eh, input int el);
    int n;
    n = 0;
    while (sout !== 1'b0 && n < 900) begin
      @(posedge clk);
      n++;
    end
    while (sout !== 1'b1 && n < 900) begin
      @(posedge clk);
      n++;
    end
    n = 0;
    while (sout === 1'b1 && n < 900) begin
      @(posedge clk);
      n++;
    end
    cmpn(n, eh);
    n = 0;
    while (sout === 1'b0 && n < 900) begin
      @(posedge clk);
      n++;
    end
    cmpn(n, el);
  endtask

  task automatic setup(input logic [3:0] m, input logic [7:0] m1, m2, v1, v2);
    wr(`TCC_OFS_CTL, 8'h00);
    wr(`TCC_OFS_MODE, {4'h0, m});
    wr(`TCC_OFS_CMODE1, m1);
    wr(`TCC_OFS_CMODE2, m2);
    wr(`TCC_OFS_CMP1, v1);
    wr(`TCC_OFS_CMP2, v2);
    wr(`TCC_OFS_CLEAR, 8'h0F);
  endtask

  initial begin
    wt(16);
    rst <= 1'b0;
    rdc(`TCC_OFS_MODE, 8'h0F);
    rdc(`TCC_OFS_CMP1, 8'hFF);
    rdc(`TCC_OFS_CTL, 8'h00);
    rdc(6'h2C, 8'h00);
    bus(1'b1, `TCC_OFS_CMP2, 8'h12, 4'h0, q);
    rdc(`TCC_OFS_CMP2, 8'hFF);
    wr(`TCC_OFS_STATUS, 8'h0F);
    rdc(`TCC_OFS_STATUS, 8'h00);
    rdc(`TCC_OFS_CLEAR, 8'h00);
    for (logic [7:0] m = 8'h01; m <= 8'h0C; m++) begin
      wr(`TCC_OFS_MODE, m);
      rdc(`TCC_OFS_MODE, m);
    end
    // Preset level only while stopped
    wr(`TCC_OFS_CTL, 8'h02);
    wt(3);
    cmpv({7'h0, sout}, 8'h01);
    wr(`TCC_OFS_CTL, 8'h00);
    wt(3);
    cmpv({7'h0, sout}, 8'h00);
    setup(tcc_pkg::TCC_M_TIMER, 8'h07, 8'h07, 8'h02, 8'h04);
    wr(`TCC_OFS_CTL, 8'h01);
    meas(5, 3);
    rdc(`TCC_OFS_STATUS, 8'h07);
    cmpv({7'h0, irq}, 8'h00);
    wr(`TCC_OFS_INTEN, 8'h06);
    wt(2);
    cmpv({7'h0, irq}, 8'h01);
    wr(`TCC_OFS_CTL, 8'h00);
    // Capture trails the cleared counter by one cycle
    wt(2);
    rdc(`TCC_OFS_CAPT, 8'h00);
    rdc(`TCC_OFS_STATUS, 8'h06);
    wr(`TCC_OFS_CLEAR, 8'h06);
    wt(2);
    cmpv({7'h0, irq}, 8'h00);
    // Capture follows the running count between two reads
    setup(tcc_pkg::TCC_M_TIMER, 8'h00, 8'h00, 8'hFF, 8'hFF);
    wr(`TCC_OFS_CTL, 8'h01);
    // Both reads must fall after counting has begun
    wt(4);
    bus(1'b0, `TCC_OFS_CAPT, 8'h00, 4'hF, q);
    rdc(`TCC_OFS_CAPT, q + 8'h03);
    setup(tcc_pkg::TCC_M_TIMER, 8'h0B, 8'h03, 8'h02, 8'h04);
    wr(`TCC_OFS_CTL, 8'h01);
    wt(30);
    wr(`TCC_OFS_CLEAR, 8'h06);
    wt(30);
    rdc(`TCC_OFS_STATUS, 8'h05);
    setup(tcc_pkg::TCC_M_TIMER, 8'h06, 8'h06, 8'h02, 8'h02);
    wr(`TCC_OFS_CLKSEL, 8'h01);
    wr(`TCC_OFS_CTL, 8'h01);
    meas(6, 6);
    setup(tcc_pkg::TCC_M_TIMER, 8'h00, 8'h00, 8'hFF, 8'hFF);
    wr(`TCC_OFS_CLKSEL, 8'h04);
    wr(`TCC_OFS_INTEN, 8'h08);
    for (int k = 0; k < 3; k++) begin
      wr(`TCC_OFS_CTL, ctl_t[k]);
      wr(`TCC_OFS_CLEAR, 8'h0F);
      i_tcc_far_model.set_edge(1'b1);
      wt(6);
      i_tcc_far_model.set_edge(1'b0);
      wt(6);
      cmpv({7'h0, irq}, exp_t[k]);
    end
    setup(tcc_pkg::TCC_M_TRIG_EXT, 8'h06, 8'h06, 8'h02, 8'h02);
    wr(`TCC_OFS_CTL, 8'h01);
    wt(30);
    cmpv({7'h0, sout}, 8'h00);
    rdc(`TCC_OFS_STATUS, 8'h00);
    i_tcc_far_model.set_edge(1'b1);
    meas(3, 3);
    setup(tcc_pkg::TCC_M_CAPT, 8'h00, 8'h00, 8'hFF, 8'hFF);
    i_tcc_far_model.set_edge(1'b0);
    wr(`TCC_OFS_CTL, 8'h01);
    wt(20);
    i_tcc_far_model.set_edge(1'b1);
    for (int k = 0; k < 2; k++) begin
      wt(20);
      bus(1'b0, `TCC_OFS_CAPT, 8'h00, 4'hF, q);
      cmpv({7'h0, q >= 8'h10 && q <= 8'h1C}, 8'h01);
    end
    setup(tcc_pkg::TCC_M_MANCH, 8'h00, 8'h00, 8'h05, 8'hFF);
    i_tcc_far_model.set_edge(1'b0);
    wr(`TCC_OFS_CLKSEL, 8'h0C);
    wr(`TCC_OFS_CTL, 8'h01);
    for (int k = 0; k < 3; k++) begin
      wt(5);
      i_tcc_far_model.set_edge(k != 1);
      wt(20);
    end
    cmpn(i_tcc_far_model.nbits, 3);
    cmpv(i_tcc_far_model.shreg, 8'h05);
    setup(tcc_pkg::TCC_M_FSK, 8'h06, 8'h06, 8'h02, 8'h06);
    wr(`TCC_OFS_CLKSEL, 8'h00);
    i_tcc_far_model.set_data(1'b1);
    wr(`TCC_OFS_CTL, 8'h01);
    meas(7, 7);
    i_tcc_far_model.set_data(1'b0);
    wt(20);
    meas(3, 3);
    // Timer 2 lines: routed output, burst gate, toggle restart and capture
    setup(tcc_pkg::TCC_M_TIMER_PT, 8'h00, 8'h00, 8'hFF, 8'hFF);
    wr(`TCC_OFS_CTL, 8'h02);
    i_tcc_far_model.set_t2(1'b0, 1'b1, 1'b0);
    wt(3);
    cmpv({6'h0, togo, sout}, 8'h03);
    i_tcc_far_model.set_t2(1'b0, 1'b0, 1'b0);
    wt(3);
    cmpv({6'h0, togo, sout}, 8'h02);
    wr(`TCC_OFS_MODE, {4'h0, tcc_pkg::TCC_M_BURST_M2});
    wt(3);
    cmpv({6'h0, togo, sout}, 8'h02);
    i_tcc_far_model.set_t2(1'b0, 1'b0, 1'b1);
    wt(3);
    cmpv({6'h0, togo, sout}, 8'h03);
    setup(tcc_pkg::TCC_M_TRIG_T2, 8'h00, 8'h00, 8'hFF, 8'hFF);
    wr(`TCC_OFS_CTL, 8'h01);
    wt(20);
    i_tcc_far_model.set_t2(1'b1, 1'b0, 1'b1);
    wt(3);
    rdc(`TCC_OFS_CAPT, 8'h14);
    results();
  end

  // Whole run needs about a thousand cycles
  initial begin
    wt(40000);
    bad_count++;
    results();
  end
endmodule
